// file: core/wds_watchdog_supervisor.sv
`timescale 1ns/1ns
`default_nettype none
module wds_watchdog_supervisor
(
   input wire logic CLK,
   input wire logic RST_B,
   input wire wds_pkg::wds_sfr_req_s SFR_REQ,
   output logic [7:0] SFR_RDATA,
   input wire logic DOUBLE_SPEED_MODE,
   input wire logic CLOCK_HALVING_SELECT,
   input wire logic POWER_DOWN,
   output logic RST_PIN,
   output logic TIMER_ENABLED
);
   import wds_pkg::*;

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   wds_key_e key_state;
   wds_key_e next_key_state;
   logic next_enabled;
   logic [WDS_PRE_W-1:0] pre;
   logic [WDS_PRE_W-1:0] next_pre;
   logic [WDS_CNT_W-1:0] cnt;
   logic [WDS_CNT_W-1:0] next_cnt;
   logic [WDS_TOTAL_W-1:0] count;
   logic [WDS_TOTAL_W-1:0] count_inc;
   logic [WDS_TOTAL_W-1:0] limit;
   logic [WDS_PERIOD_CODE_W-1:0] period_code;
   logic [WDS_PERIOD_CODE_W-1:0] next_period_code;
   logic [7:0] next_rdata;
   logic overflow;
   logic next_overflow;
   logic key_done;
   logic restart_wr;
   logic program_wr;
   logic step;
   logic run;

   assign count = {cnt, pre};
   assign count_inc = count + 21'h00_0001;
   assign limit = wds_limit(period_code);

   // ----------------------------------------------------------------
   // register decode
   // ----------------------------------------------------------------
   always_comb
   begin
      // restart register decoded for writes only
      restart_wr = SFR_REQ.wr && (SFR_REQ.addr == WDS_RESTART_REGISTER_ADDR);
      program_wr = SFR_REQ.wr && (SFR_REQ.addr == WDS_PROGRAM_REGISTER_ADDR);
      next_period_code = period_code;
      if (program_wr)
      begin
         next_period_code =
            SFR_REQ.wdata[WDS_PERIOD_CODE_LSB +: WDS_PERIOD_CODE_W];
      end
      next_rdata = WDS_READ_ZERO;
      if (SFR_REQ.rd && (SFR_REQ.addr == WDS_PROGRAM_REGISTER_ADDR))
      begin
         next_rdata = {5'h00, period_code};
      end
   end

   // ----------------------------------------------------------------
   // key sequence detector
   // ----------------------------------------------------------------
   always_comb
   begin
      next_key_state = key_state;
      key_done = 1'b0;
      // restart writes pair up even with other cycles between them
      if (restart_wr)
      begin
         unique case (key_state)
            WDS_KEY_WAIT:
            begin
               if (SFR_REQ.wdata == WDS_KEY_FIRST)
               begin
                  next_key_state = WDS_KEY_GOT_FIRST;
               end
            end
            WDS_KEY_GOT_FIRST:
            begin
               if (SFR_REQ.wdata == WDS_KEY_SECOND)
               begin
                  key_done = 1'b1;
                  next_key_state = WDS_KEY_WAIT;
               end
               else if (SFR_REQ.wdata != WDS_KEY_FIRST)
               begin
                  next_key_state = WDS_KEY_WAIT;
               end
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // prescaler and programmable counter
   // ----------------------------------------------------------------
   // only power-down and a low TIMER_ENABLED gate the tick, idle does not
   // power-down stops the tick so the count holds
   assign run = TIMER_ENABLED && !POWER_DOWN;

   always_comb
   begin
      next_enabled = TIMER_ENABLED;
      next_pre = pre;
      next_cnt = cnt;
      next_overflow = 1'b0;
      if (key_done)
      begin
         // restart clears the count, even mid step
         next_enabled = 1'b1;
         next_pre = '0;
         next_cnt = '0;
      end
      else if (overflow)
      begin
         // the pulse takes over; the outer reset follows
         next_enabled = 1'b0;
         next_pre = '0;
         next_cnt = '0;
      end
      else if (TIMER_ENABLED && step)
      begin
         // 14-bit prescaler carries into 7-bit counter
         // limit is read live, count is not touched
         // counting resumes from the held value
         {next_cnt, next_pre} = count_inc;
         // overflow when the terminal count is reached
         // overflow forces the chip reset pulse
         if (count_inc >= limit)
         begin
            next_overflow = 1'b1;
         end
      end
      // no software path clears the enable
   end

   // ----------------------------------------------------------------
   // state registers
   // ----------------------------------------------------------------
   always_ff @(posedge CLK)
   begin
      if (!RST_B)
      begin
         // a reset that ends power-down also lands here
         key_state <= WDS_KEY_WAIT;
         TIMER_ENABLED <= 1'b0;
         pre <= '0;
         cnt <= '0;
         overflow <= 1'b0;
         period_code <= WDS_PERIOD_CODE_RESET;
         SFR_RDATA <= WDS_READ_ZERO;
      end
      else
      begin
         key_state <= next_key_state;
         TIMER_ENABLED <= next_enabled;
         pre <= next_pre;
         cnt <= next_cnt;
         overflow <= next_overflow;
         period_code <= next_period_code;
         SFR_RDATA <= next_rdata;
      end
   end

   // ----------------------------------------------------------------
   // submodules
   // ----------------------------------------------------------------
   wds_tick u_tick
   (
      .clk(CLK),
      .rst_b(RST_B),
      .double_speed_mode(DOUBLE_SPEED_MODE),
      .clock_halving_select(CLOCK_HALVING_SELECT),
      .run(run),
      .clr(key_done),
      .step(step)
   );

   // overflow drives the reset pin pulse
   wds_pulse u_pulse
   (
      .clk(CLK),
      .rst_b(RST_B),
      .fire(overflow),
      .pulse(RST_PIN)
   );

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   chk_reset_disables: assert property (@(posedge CLK)
      !RST_B |=> !TIMER_ENABLED && (count == '0))
      else $error("timer not disabled after reset");

   chk_key_enables: assert property (
      @(posedge CLK) disable iff (!RST_B)
      (restart_wr && SFR_REQ.wdata == WDS_KEY_FIRST)
      ##1 (restart_wr && SFR_REQ.wdata == WDS_KEY_SECOND)
      |=> TIMER_ENABLED)
      else $error("key sequence did not enable timer");

   chk_key_clears: assert property (
      @(posedge CLK) disable iff (!RST_B)
      key_done |=> (count == '0) ##1 (count <= 21'h00_0001))
      else $error("key sequence did not clear count");

   chk_stays_enabled: assert property (
      @(posedge CLK) disable iff (!RST_B)
      TIMER_ENABLED && !overflow |=> TIMER_ENABLED)
      else $error("timer disabled without reset");

   chk_overflow_pin: assert property (
      @(posedge CLK) disable iff (!RST_B)
      $rose(overflow) |=> RST_PIN [*8])
      else $error("overflow did not raise reset pin");

   chk_limit_hit: assert property (
      @(posedge CLK) disable iff (!RST_B)
      $rose(overflow) |-> ($past(count) == limit - 21'h00_0001))
      else $error("overflow at wrong count");

   // an overflow clears the count on its own, even in power-down
   chk_pd_holds: assert property (
      @(posedge CLK) disable iff (!RST_B)
      POWER_DOWN && !key_done && !overflow ##1 POWER_DOWN
      |-> $stable(count))
      else $error("count moved in power-down");

   chk_step_adv: assert property (
      @(posedge CLK) disable iff (!RST_B)
      TIMER_ENABLED && step && !key_done && !overflow && !next_overflow
      |=> count == $past(count) + 21'h00_0001)
      else $error("count did not advance on step");

   chk_prog_read: assert property (
      @(posedge CLK) disable iff (!RST_B)
      SFR_REQ.rd && SFR_REQ.addr == WDS_PROGRAM_REGISTER_ADDR
      |=> SFR_RDATA == {5'h00, $past(period_code)})
      else $error("program register read wrong");

   chk_restart_wo: assert property (
      @(posedge CLK) disable iff (!RST_B)
      SFR_REQ.rd && SFR_REQ.addr == WDS_RESTART_REGISTER_ADDR
      |=> SFR_RDATA == WDS_READ_ZERO)
      else $error("restart register is readable");

   chk_code_reset: assert property (@(posedge CLK)
      !RST_B |=> period_code == WDS_PERIOD_CODE_RESET)
      else $error("period code not zero after reset");

   chk_code_keeps: assert property (
      @(posedge CLK) disable iff (!RST_B)
      program_wr && !step && !key_done && !overflow
      |=> $stable(count))
      else $error("period write disturbed count");

   chk_bad_second: assert property (
      @(posedge CLK) disable iff (!RST_B)
      key_state == WDS_KEY_WAIT && restart_wr
      && SFR_REQ.wdata == WDS_KEY_SECOND |-> !key_done)
      else $error("second key accepted without first");

   chk_pd_no_step: assert property (
      @(posedge CLK) disable iff (!RST_B)
      POWER_DOWN |-> !step)
      else $error("prescaler stepped in power-down");

   cov_enable: cover property (@(posedge CLK) disable iff (!RST_B)
      !TIMER_ENABLED ##1 TIMER_ENABLED);
   cov_overflow: cover property (@(posedge CLK) disable iff (!RST_B)
      $rose(RST_PIN));
   cov_pd_resume: cover property (@(posedge CLK) disable iff (!RST_B)
      TIMER_ENABLED && POWER_DOWN ##1 !POWER_DOWN ##[1:20] step);
   cov_restart: cover property (@(posedge CLK) disable iff (!RST_B)
      TIMER_ENABLED && key_done);
endmodule // wds_watchdog_supervisor
`default_nettype wire

// file: core/wds_pkg.sv
`default_nettype none
package wds_pkg;
   // ----------------------------------------------------------------
   // register map and keys
   // ----------------------------------------------------------------
   localparam logic [7:0] WDS_RESTART_REGISTER_ADDR = 8'hA6;
   localparam logic [7:0] WDS_PROGRAM_REGISTER_ADDR = 8'hA7;
   localparam logic [7:0] WDS_KEY_FIRST = 8'h1E;
   localparam logic [7:0] WDS_KEY_SECOND = 8'hE1;
   localparam logic [2:0] WDS_PERIOD_CODE_RESET = 3'h0;
   localparam logic [7:0] WDS_READ_ZERO = 8'h00;
   localparam int WDS_PERIOD_CODE_LSB = 0;
   localparam int WDS_PERIOD_CODE_W = 3;

   // ----------------------------------------------------------------
   // counter structure and timing
   // ----------------------------------------------------------------
   localparam int WDS_PRE_W = 14;
   localparam int WDS_CNT_W = 7;
   localparam int WDS_TOTAL_W = WDS_PRE_W + WDS_CNT_W;
   // tick clock periods per prescaler step
   localparam logic [2:0] WDS_TICK_DIV = 3'h6;
   // reset pin pulse, in oscillator periods
   localparam int WDS_PULSE_OSC_PERIODS = 96;
   localparam logic [6:0] WDS_PULSE_LAST = 7'(WDS_PULSE_OSC_PERIODS - 1);

   typedef enum logic [0:0]
   {
      WDS_KEY_WAIT = 1'b0,
      WDS_KEY_GOT_FIRST = 1'b1
   } wds_key_e;

   typedef struct packed
   {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } wds_sfr_req_s;

   // terminal value of the step count: (2^14 * 2^code) - 1
   function automatic logic [WDS_TOTAL_W-1:0] wds_limit(
      input logic [2:0] code);
      logic [WDS_TOTAL_W:0] one;
      one = 22'h00_0001;
      wds_limit = WDS_TOTAL_W'((one << (5'(code) + 5'(WDS_PRE_W))) - one);
   endfunction
endpackage
`default_nettype wire

// file: core/wds_tick.sv
`timescale 1ns/1ns
`default_nettype none
module wds_tick
   import wds_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic double_speed_mode,
   input wire logic clock_halving_select,
   input wire logic run,
   input wire logic clr,
   output logic step
);
   logic half;
   logic next_half;
   logic [2:0] phase;
   logic [2:0] next_phase;
   logic full_rate;
   logic tick_en;

   // ----------------------------------------------------------------
   // tick clock enable and divide by six
   // ----------------------------------------------------------------
   always_comb
   begin
      // full rate only in double speed
      full_rate = double_speed_mode && !clock_halving_select;
      tick_en = full_rate || half;
      next_half = half;
      next_phase = phase;
      // unregistered, so power-down cannot let a queued step out
      step = 1'b0;
      if (clr)
      begin
         next_half = 1'b0;
         next_phase = 3'h0;
      end
      else if (run)
      begin
         // frozen while not running, so the phase is kept too
         next_half = !half;
         if (tick_en)
         begin
            if (phase == WDS_TICK_DIV - 3'h1)
            begin
               next_phase = 3'h0;
               step = 1'b1;
            end
            else
            begin
               next_phase = phase + 3'h1;
            end
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         half <= 1'b0;
         phase <= 3'h0;
      end
      else
      begin
         half <= next_half;
         phase <= next_phase;
      end
   end
endmodule // wds_tick
`default_nettype wire

// file: core/wds_pulse.sv
`timescale 1ns/1ns
`default_nettype none
module wds_pulse
   import wds_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic fire,
   output logic pulse
);
   logic [6:0] cnt;
   logic [6:0] next_cnt;
   logic next_pulse;

   // ----------------------------------------------------------------
   // reset pin pulse of fixed width
   // ----------------------------------------------------------------
   always_comb
   begin
      next_cnt = cnt;
      next_pulse = pulse;
      if (!pulse && fire)
      begin
         next_pulse = 1'b1;
         next_cnt = 7'h00;
      end
      else if (pulse)
      begin
         // held high for 96 oscillator periods
         if (cnt == WDS_PULSE_LAST)
         begin
            next_pulse = 1'b0;
         end
         else
         begin
            next_cnt = cnt + 7'h01;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         cnt <= 7'h00;
         pulse <= 1'b0;
      end
      else
      begin
         cnt <= next_cnt;
         pulse <= next_pulse;
      end
   end

   chk_pulse_width: assert property (
      @(posedge clk) disable iff (!rst_b)
      $rose(pulse) |-> ##95 pulse ##1 !pulse)
      else $error("reset pulse width is not 96 cycles");
endmodule // wds_pulse
`default_nettype wire

// file: verif/wds_watchdog_supervisor_bench.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(what, exp, got) \
   begin \
      comparisons++; \
      if ((got) !== (exp)) \
      begin \
         err_total++; \
         $display("MISMATCH %s expected %0h seen %0h", what, exp, got); \
      end \
   end
module wds_watchdog_supervisor_bench;
   import wds_pkg::*;
   // ----------------------------------------------------------------
   // timing figures
   // ----------------------------------------------------------------
   localparam int CYC_LIMIT = 105000;
   localparam int STEP_CYCLES = int'(WDS_TICK_DIV) * ((1 << WDS_PRE_W) - 1);
   // half-rate and frozen stretches lengthen the time-out by this much
   localparam int EXTRA_CYCLES = 500 + 500 + 300;
   localparam int SLACK = 12;
   logic CLK;
   logic RST_B;
   wds_sfr_req_s SFR_REQ;
   logic [7:0] SFR_RDATA;
   logic DOUBLE_SPEED_MODE;
   logic CLOCK_HALVING_SELECT;
   logic POWER_DOWN;
   logic RST_PIN;
   logic TIMER_ENABLED;
   int err_total;
   int comparisons;
   int cyc;
   int rise_cyc;
   int width;
   int start;
   int seed;
   logic rd_d;
   logic pin_d;
   logic [7:0] rnd;
   logic [7:0] exp_v;
   logic [7:0] exp_q[$];

   wds_watchdog_supervisor wds_watchdog_supervisor_inst
   (
      .CLK(CLK),
      .RST_B(RST_B),
      .SFR_REQ(SFR_REQ),
      .SFR_RDATA(SFR_RDATA),
      .DOUBLE_SPEED_MODE(DOUBLE_SPEED_MODE),
      .CLOCK_HALVING_SELECT(CLOCK_HALVING_SELECT),
      .POWER_DOWN(POWER_DOWN),
      .RST_PIN(RST_PIN),
      .TIMER_ENABLED(TIMER_ENABLED)
   );

   initial
   begin
      CLK = 1'b0;
      forever #4 CLK = ~CLK;
   end

   // ----------------------------------------------------------------
   // bus tasks
   // ----------------------------------------------------------------
   task automatic wrap_up;
      if (err_total == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge CLK);
      #1;
   endtask

   // strobe is left up after the write; the next task call re-assigns it
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      SFR_REQ = '{1'b1, 1'b0, a, d};
      tick(1);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      SFR_REQ = '{1'b0, 1'b1, a, 8'h00};
      tick(1);
   endtask

   task automatic idle(input int n);
      SFR_REQ = '0;
      tick(n);
   endtask

   // ----------------------------------------------------------------
   // output watcher
   // ----------------------------------------------------------------
   always @(posedge CLK)
   begin
      cyc++;
      rd_d <= SFR_REQ.rd;
      pin_d <= RST_PIN;
      if (rd_d === 1'b1)
      begin
         exp_v = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx;
         `CHK("read_data", exp_v, SFR_RDATA)
      end
      if (RST_PIN === 1'b1 && pin_d !== 1'b1)
      begin
         rise_cyc = cyc;
         width = 0;
      end
      if (RST_PIN === 1'b1)
         width++;
      if (RST_PIN !== 1'b1 && pin_d === 1'b1)
         `CHK("pulse_width", WDS_PULSE_OSC_PERIODS, width)
      if (cyc == CYC_LIMIT)
      begin
         err_total++;
         wrap_up();
      end
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial
   begin
      seed = 32'hf5c9_3924;
      err_total = 0;
      comparisons = 0;
      cyc = 0;
      rise_cyc = 0;
      width = 0;
      rd_d = 1'b0;
      pin_d = 1'b0;
      RST_B = 1'b0;
      SFR_REQ = '0;
      DOUBLE_SPEED_MODE = 1'b1;
      CLOCK_HALVING_SELECT = 1'b0;
      POWER_DOWN = 1'b0;
      tick(4);
      RST_B = 1'b1;
      tick(1);
      `CHK("enabled", 1'b0, TIMER_ENABLED)
      rd(WDS_PROGRAM_REGISTER_ADDR, 8'h00);
      rd(WDS_RESTART_REGISTER_ADDR, 8'h00);
      rd(8'h55, 8'h00);
      for (int i = 0; i < 8; i++)
      begin
         wr(WDS_PROGRAM_REGISTER_ADDR, 8'(i));
         rd(WDS_PROGRAM_REGISTER_ADDR, 8'(i));
      end
      // reserved bits take a random value: any that are set must not stick
      rnd = 8'($random(seed));
      wr(WDS_PROGRAM_REGISTER_ADDR, rnd);
      rd(WDS_PROGRAM_REGISTER_ADDR, {5'h00, rnd[2:0]});
      wr(WDS_PROGRAM_REGISTER_ADDR, 8'h00);
      // broken and stray keys leave the timer off
      wr(WDS_RESTART_REGISTER_ADDR, WDS_KEY_SECOND);
      wr(WDS_RESTART_REGISTER_ADDR, WDS_KEY_FIRST);
      wr(WDS_RESTART_REGISTER_ADDR, 8'h55);
      wr(WDS_RESTART_REGISTER_ADDR, WDS_KEY_SECOND);
      idle(2);
      `CHK("enabled", 1'b0, TIMER_ENABLED)
      wr(WDS_RESTART_REGISTER_ADDR, WDS_KEY_FIRST);
      rd(WDS_PROGRAM_REGISTER_ADDR, 8'h00);
      wr(WDS_RESTART_REGISTER_ADDR, WDS_KEY_SECOND);
      idle(1);
      `CHK("enabled", 1'b1, TIMER_ENABLED)
      wr(WDS_RESTART_REGISTER_ADDR, 8'h00);
      wr(WDS_PROGRAM_REGISTER_ADDR, 8'h07);
      idle(4);
      `CHK("enabled", 1'b1, TIMER_ENABLED)
      wr(WDS_RESTART_REGISTER_ADDR, WDS_KEY_FIRST);
      wr(WDS_RESTART_REGISTER_ADDR, WDS_KEY_SECOND);
      idle(1);
      // reset that ends power-down
      POWER_DOWN = 1'b1;
      tick(3);
      RST_B = 1'b0;
      tick(2);
      RST_B = 1'b1;
      tick(1);
      `CHK("enabled", 1'b0, TIMER_ENABLED)
      POWER_DOWN = 1'b0;
      rd(WDS_PROGRAM_REGISTER_ADDR, 8'h00);
      // enable, then a late restart must clear the count
      wr(WDS_RESTART_REGISTER_ADDR, WDS_KEY_FIRST);
      wr(WDS_RESTART_REGISTER_ADDR, WDS_KEY_SECOND);
      idle(600);
      wr(WDS_RESTART_REGISTER_ADDR, WDS_KEY_FIRST);
      wr(WDS_RESTART_REGISTER_ADDR, WDS_KEY_SECOND);
      start = cyc;
      CLOCK_HALVING_SELECT = 1'b1;
      idle(1000);
      CLOCK_HALVING_SELECT = 1'b0;
      DOUBLE_SPEED_MODE = 1'b0;
      tick(1000);
      DOUBLE_SPEED_MODE = 1'b1;
      POWER_DOWN = 1'b1;
      tick(300);
      POWER_DOWN = 1'b0;
      // a long code then back: count must survive the change
      wr(WDS_PROGRAM_REGISTER_ADDR, 8'h07);
      wr(WDS_PROGRAM_REGISTER_ADDR, 8'h00);
      idle(1);
      for (int n = 0; n < 100000 && RST_PIN !== 1'b1; n++)
         tick(1);
      tick(100);
      `CHK("enabled", 1'b0, TIMER_ENABLED)
      `CHK("overflow_time", 1'b1, (rise_cyc - start >= STEP_CYCLES + EXTRA_CYCLES - SLACK) && (rise_cyc - start <= STEP_CYCLES + EXTRA_CYCLES + SLACK))
      wrap_up();
   end
endmodule // wds_watchdog_supervisor_bench
`default_nettype wire
